// [hdl/rcc_top.sv]
// Repeater configuration control: pin decode, EEPROM loader, APB registers
`timescale 1ns/1ps
`include "rcc_defs.svh"

// What this block does
// (R1) Source select high: SMBus slave; floating: EEPROM load; low: pins.
// (R2) Clock line is input as slave, driven as clock while loading EEPROM.
// (R3) Data line is read as input; transmitting only ever pulls it low.
// (R4) In either SMBus mode the slave address comes from four straps.
// (R5) Falling edge of the load trigger starts an EEPROM load.
// (R6) In EEPROM mode the load runs by itself after power-up.
// (R7) Load status output high when the load failed, low when passed.
// (R8) Equalizer pins used only in pin mode, shared by all lanes.
// (R9) De-emphasis pins used only in pin mode; otherwise per-lane registers.
// (R10) In SMBus modes level pins become address bits and bus lines.
// (R11) Rate pin: strong low gen1/2, float auto, weak low/high gen3.
// (R12) Automatic rate follows the detected incoming link rate.
// (R13) Loopback pin: low A to B, float normal, high B to A.
// (R14) Cable-absent input high forces low-power mode.
// (R15) Receiver-detect pin chooses low or high impedance termination.
// (R16) Each lane's termination follows far-end presence automatically.
// (R17) System keeps every non-floating control input at a valid level.
// (R18) Level pins resolved after power-up; remapped when source changes.
module rcc_top #(
   parameter int LANES    = 4,
   parameter int SCL_HALF = `RCC_SCL_HALF_CYC
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic [11:0]          paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire rcc_pkg::rcc_lvl_t    config_source_select,
   input  wire logic [3:0]           side_a_equalizer_level,
   input  wire logic [3:0]           side_b_equalizer_level,
   input  wire logic [3:0]           side_a_deemphasis_level,
   input  wire logic [3:0]           side_b_deemphasis_level,
   input  wire rcc_pkg::rcc_lvl_t    rate_select,
   input  wire rcc_pkg::rcc_lvl_t    loopback_select,
   input  wire rcc_pkg::rcc_lvl_t    receiver_detect_select,
   input  wire rcc_pkg::rcc_lvl_t    signal_detect_threshold,
   input  wire logic                 cable_absent_n,
   input  wire logic                 load_trigger,
   input  wire logic [1:0]           detected_rate,
   input  wire logic [LANES-1:0]     side_a_far_end_present,
   input  wire logic [LANES-1:0]     side_b_far_end_present,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   output logic                      scl_out,
   output logic                      scl_oe_n,
   output logic                      sda_out,
   output logic                      sda_oe_n,
   output logic [4*LANES-1:0]        side_a_eq_lanes,
   output logic [4*LANES-1:0]        side_b_eq_lanes,
   output logic [4*LANES-1:0]        side_a_dem_lanes,
   output logic [4*LANES-1:0]        side_b_dem_lanes,
   output logic [1:0]                link_gen,
   output logic                      deemph_enable,
   output logic                      loop_a_to_b,
   output logic                      loop_b_to_a,
   output logic                      low_power,
   output logic [LANES-1:0]          term_low_z_a,
   output logic [LANES-1:0]          term_low_z_b,
   output logic [1:0]                sd_threshold,
   output logic [3:0]                slave_address,
   output logic                      all_done,
   output logic                      irq
);
   localparam int LW = 4 * LANES;

   rcc_pkg::rcc_src_e   src;
   rcc_pkg::rcc_src_e   src_r;
   rcc_pkg::rcc_state_e st_r;
   logic [LW-1:0]       eq_a_r, eq_b_r, dem_a_r, dem_b_r;
   logic [3:0]          int_stat_r, int_mask_r, int_set;
   logic [1:0]          rate_r, loopback_select_r, receiver_detect_select_r, sdth_r;
   logic                powered_r, trig_q_r, cable_q_r;
   logic                start_load, load_pass, load_fail;
   logic [15:0]         tmr_r;
   logic                tick;
   logic [1:0]          step_r;
   logic [3:0]          bit_r;
   logic [3:0]          byte_r;
   logic [7:0]          sh_r;
   logic                fail_r, soft_load;
   logic                wr_en, rd_en;
   logic [31:0]         rd_data;
   logic                rd_err;

   always_comb begin
      if (config_source_select == `RCC_LVL_HIGH) begin
         src = rcc_pkg::RCC_SRC_SLAVE; // R1
      end else if (config_source_select == `RCC_LVL_FLOAT) begin
         src = rcc_pkg::RCC_SRC_EEPROM; // R1
      end else begin
         src = rcc_pkg::RCC_SRC_PIN; // R1
      end
   end

   // Strap levels caught once after reset release and at every source change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         powered_r <= 1'b0;
         src_r     <= rcc_pkg::RCC_SRC_PIN;
         rate_r    <= `RCC_LVL_FLOAT;
         loopback_select_r    <= `RCC_LVL_FLOAT;
         receiver_detect_select_r   <= `RCC_LVL_HIGH;
         sdth_r    <= `RCC_LVL_FLOAT;
         trig_q_r  <= 1'b1;
         cable_q_r <= 1'b1;
      end else begin
         powered_r <= 1'b1;
         src_r     <= src;
         trig_q_r  <= load_trigger;
         cable_q_r <= cable_absent_n;
         if (!powered_r || src != src_r) begin
            rate_r  <= rate_select; // R18
            loopback_select_r  <= loopback_select; // R18
            receiver_detect_select_r <= receiver_detect_select; // R18
            sdth_r  <= signal_detect_threshold; // R18
         end
      end
   end

   assign soft_load  = wr_en && paddr == `RCC_OFF_CTRL && pwdata[0];
   assign start_load = st_r == rcc_pkg::RCC_ST_IDLE &&
                       src == rcc_pkg::RCC_SRC_EEPROM &&
                       ((!powered_r || src_r != src) || // R6
                        (trig_q_r && !load_trigger) || soft_load); // R5
   assign tick = tmr_r == 16'h0000;

   // EEPROM master: write offset zero, repeated start, read config bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r     <= rcc_pkg::RCC_ST_IDLE;
         step_r   <= 2'h0;
         bit_r    <= 4'h0;
         byte_r   <= 4'h0;
         sh_r     <= 8'h00;
         fail_r   <= 1'b0;
         tmr_r    <= 16'h0000;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else begin
         tmr_r <= (tick || st_r == rcc_pkg::RCC_ST_IDLE) ?
                  16'(SCL_HALF - 1) : tmr_r - 16'h0001;
         case (st_r)
            rcc_pkg::RCC_ST_IDLE: begin
               scl_oe_n <= 1'b1; // R2
               sda_oe_n <= 1'b1;
               step_r   <= 2'h0;
               if (start_load) begin
                  st_r   <= rcc_pkg::RCC_ST_START;
                  byte_r <= 4'h0;
                  fail_r <= 1'b0;
               end
            end
            rcc_pkg::RCC_ST_START: if (tick) begin
               step_r <= step_r + 2'h1;
               if (step_r == 2'h0) begin
                  sda_oe_n <= 1'b1;
                  scl_oe_n <= 1'b1;
               end else if (step_r == 2'h1) begin
                  sda_oe_n <= 1'b0; // R3
               end else begin
                  scl_oe_n <= 1'b0; // R2
                  st_r     <= rcc_pkg::RCC_ST_BIT;
                  step_r   <= 2'h0;
                  bit_r    <= 4'h0;
                  sh_r     <= (byte_r == 4'h0) ? {`RCC_EE_ADDR, 1'b0} :
                              (byte_r == 4'h1) ? 8'h00 :
                              {`RCC_EE_ADDR, 1'b1};
               end
            end
            rcc_pkg::RCC_ST_BIT: if (tick) begin
               if (step_r == 2'h0) begin
                  // Data changes only while the clock is low
                  if (bit_r == 4'h8) begin
                     sda_oe_n <= !(byte_r > 4'h2 &&
                                   byte_r != 4'(`RCC_CFG_BYTES + 2));
                  end else begin
                     sda_oe_n <= byte_r > 4'h2 || sh_r[7]; // R3
                  end
                  step_r <= 2'h1;
               end else if (step_r == 2'h1) begin
                  scl_oe_n <= 1'b1;
                  step_r   <= 2'h2;
               end else if (scl_in) begin
                  // Waits here while the EEPROM stretches the clock
                  scl_oe_n <= 1'b0; // R2
                  step_r   <= 2'h0;
                  bit_r    <= bit_r + 4'h1;
                  if (bit_r != 4'h8) begin
                     sh_r <= {sh_r[6:0], sda_in};
                  end else if (byte_r < 4'h3 && sda_in) begin
                     fail_r <= 1'b1;
                     st_r   <= rcc_pkg::RCC_ST_STOP;
                  end else begin
                     byte_r <= byte_r + 4'h1;
                     bit_r  <= 4'h0;
                     sh_r   <= 8'h00;
                     if (byte_r == 4'h1) begin
                        st_r <= rcc_pkg::RCC_ST_START;
                     end else if (byte_r == 4'(`RCC_CFG_BYTES + 2)) begin
                        st_r <= rcc_pkg::RCC_ST_STOP;
                     end
                  end
               end
            end
            default: if (tick) begin
               step_r <= step_r + 2'h1;
               if (step_r == 2'h0) begin
                  sda_oe_n <= 1'b0;
               end else if (step_r == 2'h1) begin
                  scl_oe_n <= 1'b1;
               end else begin
                  sda_oe_n <= 1'b1;
                  st_r     <= rcc_pkg::RCC_ST_IDLE;
               end
            end
         endcase
      end
   end

   assign load_fail = st_r == rcc_pkg::RCC_ST_STOP && step_r == 2'h2 &&
                      tick && fail_r;
   assign load_pass = st_r == rcc_pkg::RCC_ST_STOP && step_r == 2'h2 &&
                      tick && !fail_r;

   // Loaded byte k lands in nibble pair k+1 of eq A, eq B, dem A, dem B; the last byte wraps to pair 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eq_a_r  <= LW'(`RCC_LANE_RST);
         eq_b_r  <= LW'(`RCC_LANE_RST);
         dem_a_r <= LW'(`RCC_LANE_RST);
         dem_b_r <= LW'(`RCC_LANE_RST);
      end else if (st_r == rcc_pkg::RCC_ST_BIT && tick && step_r == 2'h2 &&
                   scl_in && bit_r == 4'h8 && byte_r > 4'h2) begin
         case (byte_r[2:1])
            2'h1: eq_a_r[{byte_r[0], 3'h0} +: 8] <= sh_r;
            2'h2: eq_b_r[{byte_r[0], 3'h0} +: 8] <= sh_r;
            2'h3: dem_a_r[{byte_r[0], 3'h0} +: 8] <= sh_r;
            default: dem_b_r[{byte_r[0], 3'h0} +: 8] <= sh_r;
         endcase
      end else if (wr_en) begin
         if (paddr == `RCC_OFF_EQ_A) begin
            eq_a_r <= pwdata[LW-1:0];
         end else if (paddr == `RCC_OFF_EQ_B) begin
            eq_b_r <= pwdata[LW-1:0];
         end else if (paddr == `RCC_OFF_DEM_A) begin
            dem_a_r <= pwdata[LW-1:0];
         end else if (paddr == `RCC_OFF_DEM_B) begin
            dem_b_r <= pwdata[LW-1:0];
         end
      end
   end

   // Lane controls; pins shared by all lanes only in pin mode
   generate
      for (genvar l = 0; l < LANES; l++) begin : g_lane
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               side_a_eq_lanes[4*l +: 4]  <= 4'h0;
               side_b_eq_lanes[4*l +: 4]  <= 4'h0;
               side_a_dem_lanes[4*l +: 4] <= 4'h0;
               side_b_dem_lanes[4*l +: 4] <= 4'h0;
               term_low_z_a[l]            <= 1'b0;
               term_low_z_b[l]            <= 1'b0;
            end else begin
               if (src == rcc_pkg::RCC_SRC_PIN) begin
                  side_a_eq_lanes[4*l +: 4]  <= side_a_equalizer_level; // R8
                  side_b_eq_lanes[4*l +: 4]  <= side_b_equalizer_level; // R8
                  side_a_dem_lanes[4*l +: 4] <= side_a_deemphasis_level; // R9
                  side_b_dem_lanes[4*l +: 4] <= side_b_deemphasis_level; // R9
               end else begin
                  side_a_eq_lanes[4*l +: 4]  <= eq_a_r[4*l +: 4]; // R8
                  side_b_eq_lanes[4*l +: 4]  <= eq_b_r[4*l +: 4]; // R8
                  side_a_dem_lanes[4*l +: 4] <= dem_a_r[4*l +: 4]; // R9
                  side_b_dem_lanes[4*l +: 4] <= dem_b_r[4*l +: 4]; // R9
               end
               // Low level keeps the high-impedance termination
               term_low_z_a[l] <= !cable_absent_n &&
                                  receiver_detect_select_r != `RCC_LVL_LOW && // R15
                                  side_a_far_end_present[l]; // R16
               term_low_z_b[l] <= !cable_absent_n &&
                                  receiver_detect_select_r != `RCC_LVL_LOW && // R15
                                  side_b_far_end_present[l]; // R16
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_gen      <= `RCC_GEN1;
         deemph_enable <= 1'b1;
         loop_a_to_b   <= 1'b0;
         loop_b_to_a   <= 1'b0;
         low_power     <= 1'b1;
         sd_threshold  <= `RCC_LVL_FLOAT;
         slave_address <= 4'h0;
         all_done      <= `RCC_DONE_RST;
         scl_out       <= 1'b0;
         sda_out       <= 1'b0;
      end else begin
         scl_out <= 1'b0; // R2
         sda_out <= 1'b0; // R3
         if (rate_r == `RCC_LVL_LOW) begin
            link_gen      <= (detected_rate == `RCC_GEN1) ? `RCC_GEN1 :
                             `RCC_GEN2; // R11
            deemph_enable <= 1'b1;
         end else if (rate_r == `RCC_LVL_FLOAT) begin
            link_gen      <= detected_rate; // R12
            deemph_enable <= detected_rate != `RCC_GEN3; // R12
         end else begin
            link_gen      <= `RCC_GEN3; // R11
            deemph_enable <= rate_r == `RCC_LVL_HIGH; // R11
         end
         loop_a_to_b  <= loopback_select_r == `RCC_LVL_LOW; // R13
         loop_b_to_a  <= loopback_select_r == `RCC_LVL_HIGH; // R13
         low_power    <= cable_absent_n; // R14
         sd_threshold <= sdth_r;
         if (src != rcc_pkg::RCC_SRC_PIN) begin
            // Equalizer B pins give bits 3:2, de-emphasis B bits 1:0
            slave_address <= {side_b_equalizer_level[0],
                              side_b_equalizer_level[2],
                              side_b_deemphasis_level[0],
                              side_b_deemphasis_level[2]}; // R4 R10
         end
         if (load_fail) begin
            all_done <= 1'b1; // R7
         end else if (load_pass) begin
            all_done <= 1'b0; // R7
         end
      end
   end

   // APB slave: no wait states, errors on unmapped words
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign int_set = {powered_r && cable_q_r != cable_absent_n,
                     powered_r && src_r != src, load_fail, load_pass};

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      if (paddr == `RCC_OFF_CTRL) begin
         rd_data = 32'h0000_0000;
      end else if (paddr == `RCC_OFF_STATUS) begin
         rd_data = {21'h00000, low_power, link_gen, slave_address,
                    all_done, st_r != rcc_pkg::RCC_ST_IDLE, src_r};
      end else if (paddr == `RCC_OFF_EQ_A) begin
         rd_data = 32'(eq_a_r);
      end else if (paddr == `RCC_OFF_EQ_B) begin
         rd_data = 32'(eq_b_r);
      end else if (paddr == `RCC_OFF_DEM_A) begin
         rd_data = 32'(dem_a_r);
      end else if (paddr == `RCC_OFF_DEM_B) begin
         rd_data = 32'(dem_b_r);
      end else if (paddr == `RCC_OFF_INT_STAT) begin
         rd_data = {28'h0000000, int_stat_r};
      end else if (paddr == `RCC_OFF_INT_MASK) begin
         rd_data = {28'h0000000, int_mask_r};
      end else begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && rd_err;
         prdata  <= rd_en ? rd_data : 32'h0000_0000;
      end
   end

   // A new event in the clearing cycle keeps its bit set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= `RCC_INT_RST;
         int_mask_r <= `RCC_MASK_RST;
         irq        <= 1'b0;
      end else begin
         int_stat_r <= (int_stat_r & ~((wr_en &&
                        paddr == `RCC_OFF_INT_STAT) ? pwdata[3:0] : 4'h0))
                       | int_set;
         if (wr_en && paddr == `RCC_OFF_INT_MASK) begin
            int_mask_r <= pwdata[3:0];
         end
         irq <= |(int_stat_r & int_mask_r);
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_trig_fall;
      trig_q_r && !load_trigger && src == rcc_pkg::RCC_SRC_EEPROM &&
      st_r == rcc_pkg::RCC_ST_IDLE;
   endsequence
   sequence s_load_begun;
      st_r == rcc_pkg::RCC_ST_START ##1 st_r == rcc_pkg::RCC_ST_START;
   endsequence
   property p_trig_load;
      s_trig_fall |=> s_load_begun;
   endproperty
   a_trig_load: assert property (p_trig_load) // R5
      else $error("load trigger fall did not start a load");
   property p_pin_eq;
      src == rcc_pkg::RCC_SRC_PIN && powered_r |=>
         side_a_eq_lanes == {LANES{$past(side_a_equalizer_level)}};
   endproperty
   a_pin_eq: assert property (p_pin_eq) // R8
      else $error("pin mode equalizer not shared by lanes");
   property p_reg_dem;
      src == rcc_pkg::RCC_SRC_SLAVE && !wr_en |=>
         side_b_dem_lanes == $past(dem_b_r);
   endproperty
   a_reg_dem: assert property (p_reg_dem) // R9
      else $error("register mode de-emphasis not per lane");
   property p_sda_od;
      !sda_oe_n |-> !sda_out && st_r != rcc_pkg::RCC_ST_IDLE;
   endproperty
   a_sda_od: assert property (p_sda_od) // R3
      else $error("data line driven outside a load or driven high");
   property p_scl_slave;
      src == rcc_pkg::RCC_SRC_SLAVE && st_r == rcc_pkg::RCC_ST_IDLE
         |=> scl_oe_n [*2];
   endproperty
   a_scl_slave: assert property (p_scl_slave) // R2
      else $error("clock line driven in slave mode");
   property p_fail_flag;
      load_fail |=> all_done ##1 irq || !int_mask_r[`RCC_INT_FAIL];
   endproperty
   a_fail_flag: assert property (p_fail_flag) // R7
      else $error("failed load not reported");
   property p_loopback_select;
      loopback_select_r == `RCC_LVL_LOW |=> loop_a_to_b && !loop_b_to_a;
   endproperty
   a_loopback_select: assert property (p_loopback_select) // R13
      else $error("loopback low did not route A to B");
   property p_cable;
      cable_absent_n |=> low_power && term_low_z_a == '0;
   endproperty
   a_cable: assert property (p_cable) // R14
      else $error("missing cable did not force low power");
   property p_rate3;
      rate_r == `RCC_LVL_WLOW |=> link_gen == `RCC_GEN3 && !deemph_enable;
   endproperty
   a_rate3: assert property (p_rate3) // R11
      else $error("weak low rate did not give gen3 without de-emphasis");
endmodule : rcc_top

// [hdl/rcc_defs.svh]
// Offsets, field codes, reset values and timing counts of the config block
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH

`define RCC_OFF_CTRL      12'h000
`define RCC_OFF_STATUS    12'h004
`define RCC_OFF_EQ_A      12'h008
`define RCC_OFF_EQ_B      12'h00c
`define RCC_OFF_DEM_A     12'h010
`define RCC_OFF_DEM_B     12'h014
`define RCC_OFF_INT_STAT  12'h018
`define RCC_OFF_INT_MASK  12'h01c

`define RCC_LVL_LOW       2'h0
`define RCC_LVL_WLOW      2'h1
`define RCC_LVL_FLOAT     2'h2
`define RCC_LVL_HIGH      2'h3

`define RCC_GEN1          2'h0
`define RCC_GEN2          2'h1
`define RCC_GEN3          2'h2

`define RCC_INT_PASS      0
`define RCC_INT_FAIL      1
`define RCC_INT_SRC       2
`define RCC_INT_CABLE     3
`define RCC_INT_RST       4'h0
`define RCC_MASK_RST      4'h0
`define RCC_LANE_RST      16'h0000
`define RCC_DONE_RST      1'b1

`define RCC_EE_ADDR       7'h50
`define RCC_CFG_BYTES     8
`define RCC_CLK_MHZ       10
`define RCC_SCL_HALF_NS   5000
`define RCC_SCL_HALF_CYC  ((`RCC_SCL_HALF_NS * `RCC_CLK_MHZ + 999) / 1000)

`endif

// [hdl/rcc_pkg.sv]
// Types shared by the configuration control block
package rcc_pkg;
   typedef logic [1:0] rcc_lvl_t;
   typedef enum logic [1:0] {
      RCC_SRC_PIN,
      RCC_SRC_SLAVE,
      RCC_SRC_EEPROM
   } rcc_src_e;
   typedef enum logic [1:0] {
      RCC_ST_IDLE,
      RCC_ST_START,
      RCC_ST_BIT,
      RCC_ST_STOP
   } rcc_state_e;
endpackage : rcc_pkg

// [dv/rcc_eeprom_model.sv]
// Behavioural configuration EEPROM on the open-drain two-wire bus
`timescale 1ns/1ps
module rcc_eeprom_model #(
   parameter logic [63:0] IMAGE = 64'h0123456789abcdef
) (
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic nack,
   output logic      pull_n
);
   int         bitn = 0;
   int         k = 0;
   logic       fst = 1'b0;
   logic       dat = 1'b0;
   logic       ok = 1'b0;
   logic [7:0] sh = 8'h00;
   initial pull_n = 1'b1;
   always @(negedge sda) if (scl === 1'b1) begin
      fst = 1'b1;
      bitn = 0;
   end
   always @(posedge sda) if (scl === 1'b1) begin
      dat = 1'b0;
      fst = 1'b0;
   end
   always @(posedge scl) begin
      if (bitn < 8) sh = {sh[6:0], sda};
      bitn = bitn + 1;
      if (bitn == 8 && fst) ok = (sh[7:1] == 7'h50) && !nack;
      if (bitn == 9) begin
         bitn = 0;
         if (dat) k = k + 1;
         if (fst && sh[0]) k = 0;
         if (fst && sh[0]) dat = 1'b1;
         fst = 1'b0;
      end
   end
   // Released line floats to the pull-up level
   always @(negedge scl) begin
      if (!dat) pull_n = !(bitn == 8 && ok);
      else if (bitn == 8 || k > 7) pull_n = 1'b1;
      else pull_n = IMAGE[63 - 8 * k - bitn];
   end
endmodule : rcc_eeprom_model

// [dv/repeater_config_control_bench.sv]
// Self-checking bench for the repeater configuration control block
`timescale 1ns/1ps
`include "rcc_defs.svh"
module repeater_config_control_bench;
   localparam logic [63:0] IMG = 64'h0123456789abcdef;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic pready, pslverr, cable_absent_n = 0, load_trigger = 1;
   logic scl_out, scl_oe_n, sda_out, sda_oe_n, deemph_enable, irq;
   logic loop_a_to_b, loop_b_to_a, low_power, all_done, pull_n;
   logic nack = 0, saw_scl = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [3:0] side_a_equalizer_level = 0, side_b_equalizer_level = 0;
   logic [3:0] side_a_deemphasis_level = 0, side_b_deemphasis_level = 0;
   logic [3:0] side_a_far_end_present = 0, side_b_far_end_present = 0;
   logic [3:0] term_low_z_a, term_low_z_b, slave_address;
   logic [15:0] side_a_eq_lanes, side_b_eq_lanes;
   logic [15:0] side_a_dem_lanes, side_b_dem_lanes;
   logic [1:0] detected_rate = 0, link_gen, sd_threshold;
   rcc_pkg::rcc_lvl_t config_source_select = 0, rate_select = 0;
   rcc_pkg::rcc_lvl_t loopback_select = 2, receiver_detect_select = 3;
   rcc_pkg::rcc_lvl_t signal_detect_threshold = 2;
   logic [32:0] rq[$];
   int error_cnt = 0, total_checks = 0;
   wire scl_w = scl_oe_n;
   wire sda_w = sda_oe_n & pull_n;
   rcc_top #(.SCL_HALF(4)) i_dut (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .config_source_select, .side_a_equalizer_level,
      .side_b_equalizer_level, .side_a_deemphasis_level,
      .side_b_deemphasis_level, .rate_select, .loopback_select,
      .receiver_detect_select, .signal_detect_threshold, .cable_absent_n,
      .load_trigger, .detected_rate, .side_a_far_end_present,
      .side_b_far_end_present, .scl_in(scl_w), .sda_in(sda_w), .scl_out,
      .scl_oe_n, .sda_out, .sda_oe_n, .side_a_eq_lanes, .side_b_eq_lanes,
      .side_a_dem_lanes, .side_b_dem_lanes, .link_gen, .deemph_enable,
      .loop_a_to_b, .loop_b_to_a, .low_power, .term_low_z_a, .term_low_z_b,
      .sd_threshold, .slave_address, .all_done, .irq);
   rcc_eeprom_model #(.IMAGE(IMG)) i_mem (
      .scl(scl_w), .sda(sda_w), .nack, .pull_n);
   always #50 pclk = ~pclk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) rq.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rst;
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask : rst
   task automatic wait_done(input logic v);
      int n;
      n = 0;
      while (all_done !== v && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      check(all_done, v);
   endtask : wait_done
   // Reads are noted by the driver and compared here when answered
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0)
      begin
         check(prdata, rq[0][31:0]);
         check(pslverr, rq[0][32]);
         void'(rq.pop_front());
      end
      if (!(sda_oe_n & scl_oe_n)) check({scl_out, sda_out}, 0);
      if (scl_oe_n === 1'b0) saw_scl <= 1'b1;
   end
   initial begin
      #2_000_000;
      error_cnt++;
      final_report;
   end
   initial begin
      int i;
      logic [31:0] r;
      logic [15:0] v;
      void'($urandom(20904));
      for (i = 0; i < 4; i++) begin
         r = $urandom;
         {side_a_equalizer_level, side_b_equalizer_level} <= r[15:8];
         {side_a_deemphasis_level, side_b_deemphasis_level} <= r[7:0];
         {side_a_far_end_present, side_b_far_end_present} <= r[23:16];
         signal_detect_threshold <= r[25:24];
         cable_absent_n <= r[26];
         detected_rate <= r[28] ? 2'h2 : {1'b0, r[27]};
         receiver_detect_select <= r[29] ? 2'h3 : 2'h0;
         rate_select <= 2'(i);
         loopback_select <= 2'(i);
         rst;
         check(side_a_eq_lanes, {4{r[15:12]}});
         check(side_b_eq_lanes, {4{r[11:8]}});
         check(side_a_dem_lanes, {4{r[7:4]}});
         check(side_b_dem_lanes, {4{r[3:0]}});
         check(link_gen, i == 0 ? (r[28:27] == 0 ? 0 : 1) :
               i == 2 ? detected_rate : 2);
         if (i != 2) check(deemph_enable, i != 1);
         if (i != 1) check({loop_a_to_b, loop_b_to_a}, {i < 1, i > 2});
         check(low_power, r[26]);
         check(term_low_z_a, r[29] && !r[26] ? r[23:20] : 0);
         check(term_low_z_b, r[29] && !r[26] ? r[19:16] : 0);
         check(sd_threshold, r[25:24]);
         $display("pin mode case %0d done", i);
      end
      config_source_select <= 2'h3;
      repeat (4) @(posedge pclk);
      check(slave_address, {r[8], r[10], r[0], r[2]});
      check({scl_oe_n, sda_oe_n}, 2'h3);
      apb(0, `RCC_OFF_STATUS, 0, {22'h0, r[26], 2'h2,
          r[8], r[10], r[0], r[2], 4'h9});
      apb(0, `RCC_OFF_INT_STAT, 0, 33'h4);
      apb(1, `RCC_OFF_INT_MASK, 32'h4, 0);
      repeat (2) @(posedge pclk);
      check(irq, 1'b1);
      apb(1, `RCC_OFF_INT_STAT, 32'h4, 0);
      repeat (2) @(posedge pclk);
      check(irq, 1'b0);
      v = 16'($urandom);
      apb(1, `RCC_OFF_EQ_A, {16'h0, v}, 0);
      apb(0, `RCC_OFF_EQ_A, 0, {17'h0, v});
      check(side_a_eq_lanes, v);
      apb(0, 12'h020, 0, {1'b1, 32'h0});
      $display("slave mode done");
      config_source_select <= 2'h2;
      rst;
      wait_done(1'b0);
      check(saw_scl, 1'b1);
      apb(0, `RCC_OFF_EQ_A, 0, {17'h0, IMG[63:56], IMG[7:0]});
      apb(0, `RCC_OFF_EQ_B, 0, {17'h0, IMG[47:40], IMG[55:48]});
      apb(0, `RCC_OFF_DEM_A, 0, {17'h0, IMG[31:24], IMG[39:32]});
      apb(0, `RCC_OFF_DEM_B, 0, {17'h0, IMG[15:8], IMG[23:16]});
      check(side_b_dem_lanes, {IMG[15:8], IMG[23:16]});
      nack <= 1'b1;
      apb(1, `RCC_OFF_INT_MASK, 32'h2, 0);
      load_trigger <= 1'b0;
      wait_done(1'b1);
      repeat (2) @(posedge pclk);
      check(irq, 1'b1);
      apb(0, `RCC_OFF_INT_STAT, 0, 33'h3);
      $display("eeprom mode done");
      final_report;
   end
endmodule : repeater_config_control_bench
